// ### logic/pdf_pin_route.sv
`timescale 1ns/1ps
// per-pin routing between gpio and the external data bus
module pdf_pin_route (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [15:0]       func_sel,
  input  wire logic [15:0]       direction,
  input  wire logic [15:0]       gpio_out,
  input  wire logic [1:0]        mode,
  input  wire logic [15:0]       bus_dout,
  input  wire logic              bus_drive,
  output pdf_pkg::pdf_pin_ctl_t  ctl_q,
  output logic [15:0]            pin_o_q,
  output logic [15:0]            pin_oe_q
);
  logic [15:0]           bus_sel;
  pdf_pkg::pdf_pin_ctl_t ctl_d;
  logic [15:0]           pin_o_d;
  logic [15:0]           pin_oe_d;

  // rom-off modes force the data bus, single chip forces gpio
  assign bus_sel = (mode == pdf_pkg::PDF_ROM_OFF_8 ||
                    mode == pdf_pkg::PDF_ROM_OFF_16) ? 16'hffff :   // R4
                   (mode == pdf_pkg::PDF_SINGLE)     ? 16'h0000 :   // R5
                   func_sel;                                 // R1 R2 R3 R6

  assign ctl_d.bus_sel  = bus_sel;
  assign ctl_d.gpio_oe  = direction & ~bus_sel;                      // R8
  assign ctl_d.gpio_out = gpio_out;
  // bit i of each vector touches only pin i
  assign pin_o_d  = (bus_sel & bus_dout) | (~bus_sel & gpio_out);   // R2
  assign pin_oe_d = (bus_sel & {16{bus_drive}}) | ctl_d.gpio_oe;   // R3 R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q    <= '0;
      pin_o_q  <= 16'h0000;
      pin_oe_q <= 16'h0000;
    end else begin
      ctl_q    <= ctl_d;
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end
endmodule : pdf_pin_route

// ### logic/pdf_pkg.sv
package pdf_pkg;
  localparam int          NPINS          = 16;
  // register byte offsets on the apb window
  localparam logic [11:0] FUNC_SEL_OFF   = 12'h000;
  localparam logic [11:0] DIRECTION_OFF  = 12'h004;
  localparam logic [11:0] MODE_OFF       = 12'h008;
  localparam logic [11:0] PIN_STATE_OFF  = 12'h00c;
  localparam logic [15:0] FUNC_SEL_RST   = 16'h0000;
  localparam logic [15:0] DIRECTION_RST  = 16'h0000;
  localparam logic [1:0]  MODE_RST       = 2'h3;
  localparam int          MODE_LSB       = 0;

  typedef enum logic [1:0] {
    PDF_ROM_OFF_8  = 2'h0,
    PDF_ROM_OFF_16 = 2'h1,
    PDF_ROM_ON_EXT = 2'h2,
    PDF_SINGLE     = 2'h3
  } pdf_mode_t;

  typedef struct packed {
    logic [15:0] bus_sel;
    logic [15:0] gpio_oe;
    logic [15:0] gpio_out;
  } pdf_pin_ctl_t;
endpackage : pdf_pkg

// ### logic/pdf_top.sv
// Functional notes
// R1 - each function bit steers only its own pin; zero means gpio, zero at reset
// R2 - function bit n governs pin n, for bits 0 to 15
// R3 - set bit connects pin to data bus bit of same index, bidirectional
// R4 - rom-disabled modes use data bus on every pin regardless of bit
// R5 - single-chip mode keeps every pin as gpio regardless of bit
// R6 - function bits take effect only in rom-enabled extended mode
// R7 - power-on reset clears register; other resets leave it unchanged
// R8 - gpio pin direction follows direction register: one output, zero input
// R9 - reads return last written function bits whatever the mode
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module pdf_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] bus_dout,
  input  wire logic        bus_drive,
  output logic [15:0]      bus_din,
  input  wire logic [15:0] pin_i,
  output logic [15:0]      pin_o,
  output logic [15:0]      pin_oe,
  output logic [15:0]      gpio_in,
  output logic [15:0]      bus_sel
);
  logic [15:0]           func_q;
  logic [15:0]           dir_q;
  logic [15:0]           gout_q;
  logic [1:0]            mode_q;
  logic [15:0]           pin_s1_q;
  logic [15:0]           pin_s2_q;
  logic [15:0]           gpio_in_q;
  logic [15:0]           bus_din_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;
  pdf_pkg::pdf_pin_ctl_t ctl;
  logic [15:0]           pin_o_w;
  logic [15:0]           pin_oe_w;

  wire        setup    = psel & ~penable;
  wire        acc      = psel & penable;
  wire        hit_func = paddr == pdf_pkg::FUNC_SEL_OFF;
  wire        hit_dir  = paddr == pdf_pkg::DIRECTION_OFF;
  wire        hit_mode = paddr == pdf_pkg::MODE_OFF;
  wire        hit_pins = paddr == pdf_pkg::PIN_STATE_OFF;
  wire        hit_data = paddr == pdf_pkg::PIN_STATE_OFF + 12'h004;
  wire        mapped   = hit_func | hit_dir | hit_mode | hit_pins | hit_data;
  wire        wr       = setup & pwrite & mapped;
  // read value: the stored function bits, never the overridden routing; pin state reads zero on bus_sel pins
  wire [31:0] rd_mux   =
      hit_func ? {16'h0000, func_q} :                               // R9
      hit_dir  ? {16'h0000, dir_q}  :
      hit_mode ? {30'h00000000, mode_q} :
      hit_pins ? {16'h0000, gpio_in_q} :
      hit_data ? {16'h0000, gout_q} : 32'h00000000;

  // only presetn (power-on) clears; no other reset reaches these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= pdf_pkg::FUNC_SEL_RST;                              // R7 R1
      dir_q  <= pdf_pkg::DIRECTION_RST;
      gout_q <= 16'h0000;
      mode_q <= pdf_pkg::MODE_RST;
    end else if (wr) begin
      if (hit_func) func_q <= pwdata[15:0];                         // R9
      if (hit_dir)  dir_q  <= pwdata[15:0];                         // R8
      if (hit_data) gout_q <= pwdata[15:0];
      if (hit_mode) mode_q <= pwdata[pdf_pkg::MODE_LSB +: 2];
    end
  end

  // answer registered at setup, so every access is one wait-free cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= ~mapped;
    end else if (!acc) begin
      pslverr_q <= 1'b0;
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 16'h0000;
      pin_s2_q  <= 16'h0000;
      gpio_in_q <= 16'h0000;
      bus_din_q <= 16'h0000;
    end else begin
      pin_s1_q  <= pin_i;
      pin_s2_q  <= pin_s1_q;
      gpio_in_q <= pin_s2_q & ~ctl.bus_sel;
      bus_din_q <= pin_s2_q & ctl.bus_sel;                          // R3
    end
  end

  pdf_pin_route u_route (
    .pclk      (pclk),
    .presetn   (presetn),
    .func_sel  (func_q),
    .direction (dir_q),
    .gpio_out  (gout_q),
    .mode      (mode_q),
    .bus_dout  (bus_dout),
    .bus_drive (bus_drive),
    .ctl_q     (ctl),
    .pin_o_q   (pin_o_w),
    .pin_oe_q  (pin_oe_w)
  );

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q;
  assign pin_o   = pin_o_w;
  assign pin_oe  = pin_oe_w;
  assign gpio_in = gpio_in_q;
  assign bus_din = bus_din_q;
  assign bus_sel = ctl.bus_sel;
endmodule : pdf_top

// ### sim/pdf_chk_asserts.sv
`timescale 1ns/1ps
module pdf_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, bus_drive,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [15:0] bus_dout, pin_o, pin_oe, bus_sel
);
  logic [15:0] f_q, d_q;
  logic [1:0] m_q;
  wire wr = psel && !penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {f_q, d_q, m_q} <= 34'h3;
    else if (wr && paddr == 12'h000) f_q <= pwdata[15:0];
    else if (wr && paddr == 12'h004) d_q <= pwdata[15:0];
    else if (wr && paddr == 12'h008) m_q <= pwdata[1:0];
  a_read_back: assert property (psel && penable && !pwrite && !paddr
    |-> prdata == f_q) else $error("read back");
  a_reset_zero: assert property ($rose(presetn) |-> !pin_oe && !bus_sel)
    else $error("reset");
  a_rom_off: assert property ($past(m_q) < 2 |-> &bus_sel)
    else $error("rom off");
  a_single: assert property ($past(m_q) == 3 |-> !bus_sel)
    else $error("single");
  a_ext_sel: assert property ($past(m_q) == 2 |-> bus_sel == $past(f_q))
    else $error("ext sel");
  a_gpio_dir: assert property (!((pin_oe ^ $past(d_q)) & ~bus_sel))
    else $error("gpio dir");
  a_bus_oe: assert property (!((pin_oe ^ {16{$past(bus_drive)}}) & bus_sel))
    else $error("bus oe");
  a_bus_out: assert property (!((pin_o ^ $past(bus_dout)) & pin_oe & bus_sel))
    else $error("bus out");
  cover property (&bus_sel);
  cover property ($past(m_q) == 2 && bus_sel && !(&bus_sel));
  cover property (wr);
endmodule : pdf_chk
bind pdf_top pdf_chk u_chk (.*);

// ### sim/pdf_ext.sv
`timescale 1ns/1ps
module pdf_ext (
  input wire logic pclk,
  input wire logic [15:0] pin_o, pin_oe,
  output logic [15:0] pin_i
);
  logic [15:0] n_q = 16'h0000;
  always_ff @(posedge pclk) n_q <= n_q + 16'h3c5b;
  assign pin_i = pin_oe & pin_o | ~pin_oe & n_q; // no pull: released bits wander
endmodule : pdf_ext

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic bus_drive = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  // queue note: unmapped-address flag above the expected read word
  logic [32:0] q[$], x;
  logic pslverr;
  logic [15:0] bus_din, gpio_in, v;
  logic [15:0] bus_dout = 0, r, pin_i, pin_o, pin_oe, bus_sel;
  int bad_count = 0, checks = 0;
  initial forever #25 pclk = ~pclk;
  pdf_top uut (.*);
  pdf_ext ext (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    bad_count += g !== e;
    if (g !== e) $display("[ERR] %0t %h %h", $time, g, e);
  endtask : chk
  task finish_test(input int late);
    bad_count += late;
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    if (!w) q.push_back({!(a inside {12'h000, 12'h004, 12'h008, 12'h00c,
                                     12'h010}), e});
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : xfer
  always @(posedge pclk)
    if (psel && penable && !pwrite) begin
      x = q.pop_front();
      chk(prdata, x[31:0]);
      chk(pslverr, x[32]);
    end
  initial #200000 finish_test(1);
  initial begin
    void'($urandom(32'h232d439d));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h000, 0, 0);
    for (int m = 0; m < 4; m++) begin
      r = $urandom;
      {bus_dout, bus_drive} <= 17'($urandom);
      xfer(1, 12'h004, $urandom, 0);
      xfer(1, 12'h008, m, 0);
      xfer(1, 12'h000, {16'($urandom), r}, 0);
      xfer(0, 12'h000, 0, {16'h0, r});
      chk(bus_sel, m < 2 ? 16'hffff : m == 2 ? r : 16'h0);
    end
    // single chip, all gpio outputs: pins loop back into the pin state
    xfer(1, 12'h008, 3, 0);
    xfer(1, 12'h004, 32'h0000ffff, 0);
    v = $urandom;
    xfer(1, 12'h010, {16'h0, v}, 0);
    repeat (5) @(posedge pclk);
    xfer(0, 12'h00c, 0, {16'h0, v});
    chk(gpio_in, v);
    chk(bus_din, 16'h0);
    chk(pin_oe, 16'hffff);
    xfer(0, 12'h020, 0, 0);
    // rom off: controller data reaches the bus input side
    {bus_dout, bus_drive} <= {v ^ 16'ha5c3, 1'b1};
    xfer(1, 12'h008, 0, 0);
    repeat (5) @(posedge pclk);
    chk(bus_din, v ^ 16'ha5c3);
    chk(gpio_in, 16'h0);
    finish_test(0);
  end
endmodule : tb_top
